//--- design/hpc_pkg.sv
package hpc_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h04;
  localparam logic [7:0] IRQ_RAW_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MIS_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;
  localparam logic [7:0] BATT_OFS     = 8'h14;
  localparam logic [7:0] WAKE_OFS     = 8'h18;
  localparam logic [7:0] RTC_CNT_OFS  = 8'h1C;
  localparam logic [7:0] RTC_M0_OFS   = 8'h20;
  localparam logic [7:0] RTC_M1_OFS   = 8'h24;
  localparam logic [7:0] REQ_OFS      = 8'h28;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IRQ_WR_DONE_BIT  = 0;
  localparam int IRQ_PIN_WAKE_BIT = 1;
  localparam int IRQ_BATT_LOW_BIT = 2;
  localparam int IRQ_MATCH0_BIT   = 3;
  localparam int IRQ_MATCH1_BIT   = 4;
  localparam int IRQ_WIDTH        = 5;

  localparam int CTRL_ACTIVE_BIT  = 0;
  localparam int CTRL_RTC_EN_BIT  = 1;
  localparam int CTRL_SLEEP_BIT   = 2;
  localparam int CTRL_REG_EN_BIT  = 3;

  localparam int BATT_MON_BIT     = 0;
  localparam int BATT_CANCEL_BIT  = 1;
  localparam int BATT_THR_LSB     = 2;

  localparam int WAKE_PIN_BIT     = 0;
  localparam int WAKE_RTC_BIT     = 1;
  localparam int WAKE_BATT_BIT    = 2;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [4:0] IRQ_EN_RST  = 5'h00;
  localparam logic [3:0] BATT_RST    = 4'h0;
  localparam logic [2:0] WAKE_RST    = 3'h0;
  localparam int         CLK_HZ      = 20_000_000;
  localparam int         CHECK_US    = 10;
  localparam int         CHECK_CYC   = (CLK_HZ / 1_000_000) * CHECK_US;

  typedef enum logic [1:0] {
    battery_threshold_lowest,
    battery_threshold_second,
    battery_threshold_third,
    battery_threshold_highest
  } hpc_thr_e;

  typedef enum {HPC_RUN, HPC_WAIT_CHECK, HPC_SLEEP} hpc_state_e;

  typedef struct packed {
    logic     battery_low_cancels_sleep;
    hpc_thr_e threshold;
    logic     battery_monitor_on;
  } hpc_batt_s;

endpackage

//--- design/hpc_power_control.sv
// What this block does
// - Clear request drops named pending sources
// - Per-source enable gates combined interrupt
// - Five sources: write, pin, battery, match0, match1
// - Status readable raw or masked
// - Active flag readable, survives processor reset
// - Detected low battery sets raw status
// - Abort option cancels hibernation, keeps regulator
// - Two-bit threshold field, four voltage levels
// - Hibernation request drops regulator enable
// - Wake condition reasserts regulator enable
// - Own reset only, not processor reset
// - Request write never stalls the bus
// - RTC enable gates counting, match, wake
// - Wake sources selectable independently
// - Counter equal match value flags match
// - Request waits for battery check end
`timescale 1ns/1ps
module hpc_power_control #(
  parameter int CHECK_CYCLES = hpc_pkg::CHECK_CYC,
  parameter int SEC_CYCLES   = hpc_pkg::CLK_HZ
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wake_pin_i,
  input  wire logic [3:0]  battery_below_i,
  output logic             regulator_en_o,
  output logic             irq_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic       wake_meta;
  logic       wake_sync;
  logic [3:0] batt_meta;
  logic [3:0] batt_sync;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      batt_meta <= 4'h0;
      batt_sync <= 4'h0;
    end else begin
      wake_meta <= wake_pin_i;
      wake_sync <= wake_meta;
      batt_meta <= battery_below_i;
      batt_sync <= batt_meta;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic                      active;
  logic                      rtc_en;
  logic [hpc_pkg::IRQ_WIDTH-1:0] irq_en;
  logic [hpc_pkg::IRQ_WIDTH-1:0] irq_raw;
  hpc_pkg::hpc_batt_s        batt_cfg;
  logic [2:0]                wake_cfg;
  logic [31:0]               rtc_cnt;
  logic [31:0]               match0;
  logic [31:0]               match1;
  logic [31:0]               sec_div;
  logic [31:0]               chk_cnt;
  logic                      wr_done_pend;
  hpc_pkg::hpc_state_e       state;
  hpc_pkg::hpc_state_e       next_state;

  wire wr_acc    = psel_i && penable_i && pwrite_i;
  wire wr_ctrl   = wr_acc && (paddr_i == hpc_pkg::CTRL_OFS);
  wire wr_en     = wr_acc && (paddr_i == hpc_pkg::IRQ_EN_OFS);
  wire wr_clr    = wr_acc && (paddr_i == hpc_pkg::IRQ_CLR_OFS);
  wire wr_batt   = wr_acc && (paddr_i == hpc_pkg::BATT_OFS);
  wire wr_wake   = wr_acc && (paddr_i == hpc_pkg::WAKE_OFS);
  wire wr_cnt    = wr_acc && (paddr_i == hpc_pkg::RTC_CNT_OFS);
  wire wr_m0     = wr_acc && (paddr_i == hpc_pkg::RTC_M0_OFS);
  wire wr_m1     = wr_acc && (paddr_i == hpc_pkg::RTC_M1_OFS);
  wire wr_req    = wr_acc && (paddr_i == hpc_pkg::REQ_OFS) && pwdata_i[0];
  wire wr_domain = wr_ctrl || wr_batt || wr_wake || wr_cnt || wr_m0 || wr_m1;
  wire mapped    = (paddr_i[1:0] == 2'b00) && (paddr_i <= hpc_pkg::REQ_OFS);

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ----------------------------------------
  // Events
  // ----------------------------------------
  wire [1:0] thr_sel   = batt_cfg.threshold;
  wire batt_low        = batt_cfg.battery_monitor_on && batt_sync[thr_sel];
  wire checking        = batt_cfg.battery_monitor_on && (chk_cnt != 32'h0);
  wire hit0            = rtc_en && (rtc_cnt == match0);
  wire hit1            = rtc_en && (rtc_cnt == match1);
  wire pin_ev          = wake_sync;
  wire wake_ev         = (wake_cfg[hpc_pkg::WAKE_PIN_BIT] && pin_ev) ||
                         (wake_cfg[hpc_pkg::WAKE_RTC_BIT] && (hit0 || hit1)) ||
                         (wake_cfg[hpc_pkg::WAKE_BATT_BIT] && batt_low);
  wire cancel          = batt_cfg.battery_low_cancels_sleep && batt_low;

  logic [hpc_pkg::IRQ_WIDTH-1:0] ev;
  assign ev[hpc_pkg::IRQ_WR_DONE_BIT]  = wr_done_pend;
  assign ev[hpc_pkg::IRQ_PIN_WAKE_BIT] = pin_ev;
  assign ev[hpc_pkg::IRQ_BATT_LOW_BIT] = batt_low;
  assign ev[hpc_pkg::IRQ_MATCH0_BIT]   = hit0;
  assign ev[hpc_pkg::IRQ_MATCH1_BIT]   = hit1;

  wire [hpc_pkg::IRQ_WIDTH-1:0] clr_bits = wr_clr ? pwdata_i[hpc_pkg::IRQ_WIDTH-1:0]
                                                  : '0;
  wire [hpc_pkg::IRQ_WIDTH-1:0] irq_mis  = irq_raw & irq_en;

  // ----------------------------------------
  // Interrupt registers
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_raw      <= '0;
      irq_en       <= hpc_pkg::IRQ_EN_RST;
      wr_done_pend <= 1'b0;
    end else begin
      irq_raw      <= (irq_raw & ~clr_bits) | ev;
      wr_done_pend <= wr_domain;
      if (wr_en) begin
        irq_en <= pwdata_i[hpc_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq_o = |irq_mis;

  // ----------------------------------------
  // Configuration and RTC
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active   <= 1'b0;
      rtc_en   <= 1'b0;
      batt_cfg <= hpc_pkg::BATT_RST;
      wake_cfg <= hpc_pkg::WAKE_RST;
      match0   <= 32'h0;
      match1   <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        active <= pwdata_i[hpc_pkg::CTRL_ACTIVE_BIT];
        rtc_en <= pwdata_i[hpc_pkg::CTRL_RTC_EN_BIT];
      end
      if (wr_batt) begin
        batt_cfg <= hpc_pkg::hpc_batt_s'(pwdata_i[3:0]);
      end
      if (wr_wake) begin
        wake_cfg <= pwdata_i[2:0];
      end
      if (wr_m0) begin
        match0 <= pwdata_i;
      end
      if (wr_m1) begin
        match1 <= pwdata_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rtc_cnt <= 32'h0;
      sec_div <= 32'h0;
    end else if (wr_cnt) begin
      rtc_cnt <= pwdata_i;
      sec_div <= 32'h0;
    end else if (rtc_en) begin
      if (sec_div == 32'(SEC_CYCLES - 1)) begin
        sec_div <= 32'h0;
        rtc_cnt <= rtc_cnt + 32'h1;
      end else begin
        sec_div <= sec_div + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Battery check window
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_cnt <= 32'h0;
    end else if (wr_batt && pwdata_i[hpc_pkg::BATT_MON_BIT]) begin
      chk_cnt <= 32'(CHECK_CYCLES);
    end else if (chk_cnt != 32'h0) begin
      chk_cnt <= chk_cnt - 32'h1;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      hpc_pkg::HPC_RUN: begin
        if (wr_req) begin
          next_state = hpc_pkg::HPC_WAIT_CHECK;
        end
      end
      hpc_pkg::HPC_WAIT_CHECK: begin
        if (cancel) begin
          next_state = hpc_pkg::HPC_RUN;
        end else if (!checking) begin
          next_state = hpc_pkg::HPC_SLEEP;
        end
      end
      hpc_pkg::HPC_SLEEP: begin
        if (wake_ev || cancel) begin
          next_state = hpc_pkg::HPC_RUN;
        end
      end
      default: next_state = hpc_pkg::HPC_RUN;
    endcase
  end

  // Own reset only; processor power-on reset does not reach here
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= hpc_pkg::HPC_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign regulator_en_o = (state != hpc_pkg::HPC_SLEEP);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    case (paddr_i)
      hpc_pkg::CTRL_OFS:    next_rdata = {28'h0, regulator_en_o, (state != hpc_pkg::HPC_RUN),
                                          rtc_en, active};
      hpc_pkg::IRQ_EN_OFS:  next_rdata = {27'h0, irq_en};
      hpc_pkg::IRQ_RAW_OFS: next_rdata = {27'h0, irq_raw};
      hpc_pkg::IRQ_MIS_OFS: next_rdata = {27'h0, irq_mis};
      hpc_pkg::BATT_OFS:    next_rdata = {28'h0, batt_cfg};
      hpc_pkg::WAKE_OFS:    next_rdata = {29'h0, wake_cfg};
      hpc_pkg::RTC_CNT_OFS: next_rdata = rtc_cnt;
      hpc_pkg::RTC_M0_OFS:  next_rdata = match0;
      hpc_pkg::RTC_M1_OFS:  next_rdata = match1;
      default:              next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

endmodule

//--- dv/hpc_power_control_props.sv
`timescale 1ns/1ps
module hpc_power_control_props (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        wake_pin_i,
  input wire logic        regulator_en_o,
  input wire logic        irq_o
);
  // ----------------------------------------
  // Bus decode and register shadows
  // ----------------------------------------
  wire        wr = psel_i && penable_i && pwrite_i;
  wire        rd = psel_i && penable_i && !pwrite_i;
  logic [4:0] en_q;
  logic       wk_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= 5'h00;
      wk_q <= 1'b0;
    end else begin
      if (wr && paddr_i == hpc_pkg::IRQ_EN_OFS) en_q <= pwdata_i[4:0];
      if (wr && paddr_i == hpc_pkg::WAKE_OFS) wk_q <= pwdata_i[0];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ctrl_wr;
    wr && paddr_i == hpc_pkg::CTRL_OFS && en_q[0];
  endsequence
  sequence s_irq_up;
    ##[2:3] irq_o;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  no_stall_a: assert property (pready_o)
    else $error("pready low");
  bad_addr_a: assert property (psel_i && penable_i && (paddr_i > 8'h28 || paddr_i[1:0] != 2'h0) |-> pslverr_o)
    else $error("no slave error");
  clr_reads_zero_a: assert property (rd && paddr_i == hpc_pkg::IRQ_CLR_OFS |-> prdata_o == 32'h0)
    else $error("clear reads nonzero");
  masked_irq_a: assert property (rd && paddr_i == hpc_pkg::IRQ_MIS_OFS |-> (|prdata_o[4:0]) == $past(irq_o))
    else $error("masked status and irq differ");
  ctrl_reg_a: assert property (rd && paddr_i == hpc_pkg::CTRL_OFS |-> prdata_o[3] == $past(regulator_en_o))
    else $error("regulator bit wrong");
  mask_off_a: assert property (wr && paddr_i == hpc_pkg::IRQ_EN_OFS && pwdata_i[4:0] == 5'h00 |=> !irq_o)
    else $error("masked irq still high");
  wr_done_a: assert property (s_ctrl_wr |-> s_irq_up)
    else $error("write complete missing");
  pin_wake_a: assert property (!regulator_en_o && wk_q && wake_pin_i |-> ##[0:4] regulator_en_o)
    else $error("pin wake late");
  check_hold_a: assert property (wr && paddr_i == hpc_pkg::BATT_OFS && pwdata_i[0] && regulator_en_o |=> regulator_en_o [*4])
    else $error("sleep during check");
endmodule
bind hpc_power_control hpc_power_control_props u_props (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .wake_pin_i(wake_pin_i),
  .regulator_en_o(regulator_en_o), .irq_o(irq_o));

//--- dv/hpc_supply_model.sv
`timescale 1ns/1ps
module hpc_supply_model (
  input  wire logic        clock_i,
  input  wire logic        regulator_en_i,
  input  wire logic [11:0] batt_mv_i,
  output logic [3:0]       battery_below_o,
  output logic             power_good_o
);
  // ----------------------------------------
  // Battery comparators and processor rail
  // ----------------------------------------
  logic [3:0] ramp_q = 4'hF;
  assign battery_below_o = {batt_mv_i < 12'h9C4, batt_mv_i < 12'h8FC, batt_mv_i < 12'h834, batt_mv_i < 12'h76C};
  assign power_good_o = ramp_q[3];
  always_ff @(posedge clock_i) begin
    ramp_q <= {ramp_q[2:0], regulator_en_i};
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clock_i, reset_n_i, psel, penable, pwrite, pready, wake_pin, reg_en, irq, pgood;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  below;
  logic [11:0] batt_mv;
  int          n_fail, samples_checked, i;

  hpc_power_control #(.CHECK_CYCLES(4), .SEC_CYCLES(8)) u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(),
    .wake_pin_i(wake_pin), .battery_below_i(below), .regulator_en_o(reg_en), .irq_o(irq));
  hpc_supply_model u_supply (.clock_i(clock_i), .regulator_en_i(reg_en), .batt_mv_i(batt_mv),
    .battery_below_o(below), .power_good_o(pgood));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic wait_pg(input logic v);
    i = 0;
    while (pgood !== v && i < 200) begin
      @(posedge clock_i);
      i++;
    end
  endtask
  task automatic close_out;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    close_out;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {reset_n_i, psel, penable, pwrite, paddr, pwdata, wake_pin} = '0;
    {n_fail, samples_checked} = '0;
    batt_mv = 12'hBB8;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rc(hpc_pkg::CTRL_OFS, 32'h8);
    rc(hpc_pkg::IRQ_EN_OFS, 32'h0);
    rc(hpc_pkg::BATT_OFS, 32'h0);
    rc(hpc_pkg::WAKE_OFS, 32'h0);
    rc(8'h2C, 32'h0);
    apb(1'b1, hpc_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, hpc_pkg::IRQ_EN_OFS, 32'h1F);
    @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    rc(hpc_pkg::IRQ_MIS_OFS, 32'h1);
    rc(hpc_pkg::IRQ_RAW_OFS, 32'h1);
    apb(1'b1, hpc_pkg::IRQ_CLR_OFS, 32'h1);
    rc(hpc_pkg::IRQ_RAW_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rc(hpc_pkg::CTRL_OFS, 32'h9);
    batt_mv <= 12'h898;
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, hpc_pkg::BATT_OFS, 32'(t * 2 + 1));
      apb(1'b1, hpc_pkg::IRQ_CLR_OFS, 32'h1F);
      apb(1'b0, hpc_pkg::IRQ_RAW_OFS, 32'h0);
      chk(rd_q & 32'h4, t > 1 ? 32'h4 : 32'h0);
    end
    apb(1'b1, hpc_pkg::WAKE_OFS, 32'h1);
    apb(1'b1, hpc_pkg::BATT_OFS, 32'hF);
    apb(1'b1, hpc_pkg::REQ_OFS, 32'h1);
    repeat (20) @(posedge clock_i);
    chk({31'h0, reg_en}, 32'h1);
    rc(hpc_pkg::CTRL_OFS, 32'h9);
    batt_mv <= 12'hBB8;
    repeat (4) @(posedge clock_i);
    apb(1'b1, hpc_pkg::IRQ_CLR_OFS, 32'h1F);
    apb(1'b1, hpc_pkg::BATT_OFS, 32'h1);
    apb(1'b1, hpc_pkg::REQ_OFS, 32'h1);
    wait_pg(1'b0);
    chk({31'h0, reg_en}, 32'h0);
    rc(hpc_pkg::CTRL_OFS, 32'h5);
    wake_pin <= 1'b1;
    wait_pg(1'b1);
    chk({31'h0, reg_en}, 32'h1);
    wake_pin <= 1'b0;
    rc(hpc_pkg::IRQ_RAW_OFS, 32'h3);
    rc(hpc_pkg::CTRL_OFS, 32'h9);
    apb(1'b1, hpc_pkg::WAKE_OFS, 32'h2);
    apb(1'b1, hpc_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, hpc_pkg::RTC_CNT_OFS, 32'h0);
    apb(1'b1, hpc_pkg::RTC_M0_OFS, 32'h2);
    apb(1'b1, hpc_pkg::RTC_M1_OFS, 32'h3);
    apb(1'b1, hpc_pkg::IRQ_CLR_OFS, 32'h1F);
    apb(1'b1, hpc_pkg::REQ_OFS, 32'h1);
    wait_pg(1'b0);
    repeat (40) @(posedge clock_i);
    chk({31'h0, reg_en}, 32'h0);
    apb(1'b1, hpc_pkg::CTRL_OFS, 32'h3);
    wait_pg(1'b1);
    chk({31'h0, reg_en}, 32'h1);
    repeat (40) @(posedge clock_i);
    rc(hpc_pkg::IRQ_RAW_OFS, 32'h19);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, hpc_pkg::IRQ_EN_OFS, 32'h0);
    @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    rc(hpc_pkg::IRQ_MIS_OFS, 32'h0);
    close_out;
  end
endmodule
